// ---- core/sdlc_dac_load_ctrl.sv ----
`default_nettype none
// How it works
// - One 12-bit bus feeds six channel latches, one word per active edge.
// - A start launches six captures, one into each channel in turn.
// - Start must be high at the active edge before the loading begins.
// - Edge select high uses rising edges, low uses falling edges.
// - Direction low fills channel 0 up to 5; high fills 5 down to 0.
// - Transfer high on a rising edge updates outputs at the falling edge after two more rising edges.
// - Standby clears all stored words and halts loading until released.
// - Invert selects which reference level code 4095 maps to.
// - Invert selects the sign of the analog transfer around its reference.
module sdlc_dac_load_ctrl
  import sdlc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Pixel input pins
  input wire logic [DataWidth-1:0] pixelData,
  input wire logic sequence_start,
  input wire logic output_transfer,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Converter side
  output logic [NumChannels*DataWidth-1:0] channel_outputs,
  output logic polarity_invert,
  output logic power_down_request
);
  import sdlc_pkg::*;

  // Pin synchronisers, both phases
  logic [DataWidth+1:0] pinS1_q, pinS2_q;
  logic [DataWidth+1:0] pinN1_q, pinN2_q;
  logic [DataWidth+1:0] pinAll;
  assign pinAll = {output_transfer, sequence_start, pixelData};

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinS1_q <= '0;
      pinS2_q <= '0;
    end
    else
    begin
      pinS1_q <= pinAll;
      pinS2_q <= pinS1_q;
    end
  end

  always_ff @(negedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pinN1_q <= '0;
      pinN2_q <= '0;
    end
    else
    begin
      pinN1_q <= pinAll;
      pinN2_q <= pinN1_q;
    end
  end

  // Control register
  logic [3:0] ctl_q, ctl_d;
  logic edgeRise, dirDesc, standby;
  assign edgeRise = ctl_q[CtlEdgeSelBit];
  assign dirDesc = ctl_q[CtlDirBit];
  assign standby = ctl_q[CtlStandbyBit];

  // Rising-edge and falling-edge sequencers
  sdlc_load_if loadRise();
  sdlc_load_if loadFall();
  logic busyRise, busyFall;

  sdlc_edge_seq u_seq_rise (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .enable(edgeRise),
    .dirDesc(dirDesc),
    .sequenceStart(pinS2_q[DataWidth]),
    .dataIn(pinS2_q[DataWidth-1:0]),
    .flush(standby),
    .load(loadRise.seq),
    .busy(busyRise)
  );

  sdlc_edge_seq u_seq_fall (
    .ref_clk(~ref_clk),
    .arst_n(arst_n),
    .enable(!edgeRise),
    .dirDesc(dirDesc),
    .sequenceStart(pinN2_q[DataWidth]),
    .dataIn(pinN2_q[DataWidth-1:0]),
    .flush(standby),
    .load(loadFall.seq),
    .busy(busyFall)
  );

  // Channel latches, rising and falling domains
  logic [DataWidth-1:0] latchR_q [NumChannels];
  logic [DataWidth-1:0] latchR_d [NumChannels];
  logic [DataWidth-1:0] latchF_q [NumChannels];
  logic [DataWidth-1:0] latchF_d [NumChannels];
  logic [NumChannels-1:0] srcFall_q, srcFall_d;

  always_comb
  begin
    for (int i = 0; i < NumChannels; i++)
    begin
      latchR_d[i] = latchR_q[i];
      if (standby)
        latchR_d[i] = CodeResetValue;
      else if (loadRise.capture && loadRise.chanIdx == 3'(i))
        latchR_d[i] = loadRise.word;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NumChannels; i++)
    begin
      latchF_d[i] = latchF_q[i];
      if (standby)
        latchF_d[i] = CodeResetValue;
      else if (loadFall.capture && loadFall.chanIdx == 3'(i))
        latchF_d[i] = loadFall.word;
    end
  end

  always_comb
  begin
    srcFall_d = srcFall_q;
    for (int i = 0; i < NumChannels; i++)
    begin
      if (loadRise.capture && loadRise.chanIdx == 3'(i))
        srcFall_d[i] = 1'b0;
    end
    srcFall_d = srcFall_d | ({NumChannels{1'b1}} & ~{NumChannels{edgeRise}});
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NumChannels; i++)
        latchR_q[i] <= CodeResetValue;
      srcFall_q <= '0;
    end
    else
    begin
      latchR_q <= latchR_d;
      srcFall_q <= srcFall_d;
    end
  end

  always_ff @(negedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < NumChannels; i++)
        latchF_q[i] <= CodeResetValue;
    end
    else
      latchF_q <= latchF_d;
  end

  // Output transfer: sampled rising, applied falling
  logic xferSeen_q, xferSeen_d;
  logic [NumChannels*DataWidth-1:0] outs_q, outs_d;
  logic [15:0] xferCnt_q, xferCnt_d;

  always_comb
  begin
    xferSeen_d = pinS2_q[DataWidth+1] & !standby;
    xferCnt_d = xferCnt_q + {15'h0, xferSeen_q};
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xferSeen_q <= 1'b0;
      xferCnt_q <= '0;
    end
    else
    begin
      xferSeen_q <= xferSeen_d;
      xferCnt_q <= xferCnt_d;
    end
  end

  always_comb
  begin
    outs_d = outs_q;
    if (standby)
      outs_d = '0;
    else if (xferSeen_q)
    begin
      for (int i = 0; i < NumChannels; i++)
        outs_d[i*DataWidth +: DataWidth] = srcFall_q[i] ? latchF_q[i] : latchR_q[i];
    end
  end

  always_ff @(negedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      outs_q <= '0;
    else
      outs_q <= outs_d;
  end

  assign channel_outputs = outs_q;

  assign polarity_invert = ctl_q[CtlInvertBit];
  assign power_down_request = standby;

  // AHB-Lite slave, zero wait states
  logic aphValid_q, aphValid_d;
  logic aphWrite_q, aphWrite_d;
  logic [7:0] aphAddr_q, aphAddr_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] status;
  logic [7:0] latchOffs;
  logic [7:0] outOffs;

  assign status = {xferCnt_q, 7'h0, busyRise | busyFall,
                   1'b0, (edgeRise ? loadRise.chanIdx : loadFall.chanIdx), 3'h0,
                   busyRise | busyFall};
  assign latchOffs = haddr - OffsLatchBase;
  assign outOffs = haddr - OffsOutBase;

  always_comb
  begin
    aphValid_d = hsel & hready & htrans[1];
    aphWrite_d = hwrite;
    aphAddr_d = haddr;
    ctl_d = ctl_q;
    rdata_d = '0;
    if (aphValid_q && aphWrite_q && aphAddr_q == OffsControl)
      ctl_d = hwdata[3:0];
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      if (haddr == OffsControl)
        rdata_d = {28'h0, ctl_q};
      else if (haddr == OffsStatus)
        rdata_d = status;
      else if (latchOffs < 8'(4 * NumChannels) && !latchOffs[1] && !latchOffs[0])
        rdata_d = {20'h0, latchR_q[3'(latchOffs[4:2])] ^ latchR_q[3'(latchOffs[4:2])]
                   | (srcFall_q[3'(latchOffs[4:2])] ? latchF_q[3'(latchOffs[4:2])]
                   : latchR_q[3'(latchOffs[4:2])])};
      else if (outOffs < 8'(4 * NumChannels) && !outOffs[1] && !outOffs[0])
        rdata_d = {20'h0, outs_q[outOffs[4:2] * DataWidth +: DataWidth]};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      aphValid_q <= 1'b0;
      aphWrite_q <= 1'b0;
      aphAddr_q <= '0;
      ctl_q <= CtlResetValue;
      rdata_q <= '0;
    end
    else
    begin
      aphValid_q <= aphValid_d;
      aphWrite_q <= aphWrite_d;
      aphAddr_q <= aphAddr_d;
      ctl_q <= ctl_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  chk_xfer_applies: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (pinS2_q[DataWidth+1] && !standby) |=> ##1 (xferCnt_q == $past(xferCnt_q) + 16'h1))
    else $error("transfer not counted");
  chk_standby_clears: assert property (@(posedge ref_clk) disable iff (!arst_n)
    standby |=> (latchR_q[0] == CodeResetValue) && !busyRise)
    else $error("standby did not clear");
  chk_outputs_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (!xferSeen_q && !standby && !$past(xferSeen_q)) |-> $stable(outs_q))
    else $error("outputs changed without transfer");
  chk_edge_exclusive: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !(loadRise.capture && !edgeRise))
    else $error("rising capture while falling selected");
  chk_first_channel: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ($rose(busyRise) && !standby && edgeRise) |-> (latchR_q[dirDesc ? 5 : 0] ==
    $past(pinS2_q[DataWidth-1:0])))
    else $error("first channel wrong");
  chk_invert_out: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (aphValid_q && aphWrite_q && aphAddr_q == OffsControl) |=>
    (polarity_invert == $past(hwdata[CtlInvertBit])))
    else $error("invert level wrong");
  chk_start_ahead: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ($rose(busyRise) && edgeRise) |-> $past(pinS2_q[DataWidth], 2))
    else $error("load began without prior start");
  chk_ahb_okay: assert property (@(posedge ref_clk) disable iff (!arst_n)
    hreadyout && !hresp)
    else $error("bus answer not okay");
endmodule // sdlc_dac_load_ctrl
`default_nettype wire

// ---- core/sdlc_edge_seq.sv ----
`default_nettype none
// Sequencer for one clock phase: samples start one active edge ahead
module sdlc_edge_seq
  import sdlc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Controls, already synchronised
  input wire logic enable,
  input wire logic dirDesc,
  input wire logic sequenceStart,
  input wire logic [DataWidth-1:0] dataIn,
  input wire logic flush,
  // Loading strobes
  sdlc_load_if.seq load,
  output logic busy
);
  sdlc_state_t state_q, state_d;
  logic startSeen_q, startSeen_d;
  logic [2:0] idx_q, idx_d;
  logic [2:0] cnt_q, cnt_d;

  always_comb
  begin
    state_d = state_q;
    idx_d = idx_q;
    cnt_d = cnt_q;
    startSeen_d = enable & sequenceStart;
    load.capture = 1'b0;
    load.chanIdx = idx_q;
    load.word = dataIn;
    if (flush || !enable)
    begin
      state_d = SdlcIdle;
      startSeen_d = 1'b0;
    end
    else if (startSeen_q)
    begin
      load.capture = 1'b1;
      load.chanIdx = dirDesc ? FirstChanDesc : FirstChanAsc;
      idx_d = dirDesc ? FirstChanDesc - 3'h1 : FirstChanAsc + 3'h1;
      cnt_d = 3'h1;
      state_d = SdlcLoad;
    end
    else if (state_q != SdlcIdle)
    begin
      load.capture = 1'b1;
      idx_d = dirDesc ? idx_q - 3'h1 : idx_q + 3'h1;
      cnt_d = cnt_q + 3'h1;
      state_d = (cnt_q == 3'(NumChannels - 1)) ? SdlcIdle : SdlcLoad;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= SdlcIdle;
      startSeen_q <= 1'b0;
      idx_q <= 3'h0;
      cnt_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      startSeen_q <= startSeen_d;
      idx_q <= idx_d;
      cnt_q <= cnt_d;
    end
  end

  assign busy = (state_q != SdlcIdle);

  chk_load_length: assert property (@(posedge ref_clk) disable iff (!arst_n)
    (startSeen_q && enable && !flush) ##1 (enable && !flush && !startSeen_q) [*5] |->
    $past(busy, 4) && $past(busy, 3) && $past(busy, 2) && $past(busy) && busy ##1 !busy)
    else $error("loading cycle length wrong");
endmodule // sdlc_edge_seq
`default_nettype wire

// ---- core/sdlc_load_if.sv ----
`default_nettype none
interface sdlc_load_if;
  import sdlc_pkg::*;
  logic capture;
  logic [ChanIdxWidth-1:0] chanIdx;
  logic [DataWidth-1:0] word;
  modport seq (output capture, output chanIdx, output word);
  modport core (input capture, input chanIdx, input word);
endinterface
`default_nettype wire

// ---- core/sdlc_pkg.sv ----
`default_nettype none
package sdlc_pkg;
  localparam int DataWidth = 12;
  localparam int NumChannels = 6;
  localparam int ChanIdxWidth = 3;
  localparam logic [2:0] FirstChanAsc = 3'h0;
  localparam logic [2:0] FirstChanDesc = 3'h5;
  localparam logic [11:0] CodeFullScale = 12'hfff;
  localparam logic [11:0] CodeResetValue = 12'h000;
  // Register map, byte addresses
  localparam logic [7:0] OffsControl = 8'h00;
  localparam logic [7:0] OffsStatus = 8'h04;
  localparam logic [7:0] OffsLatchBase = 8'h10;
  localparam logic [7:0] OffsOutBase = 8'h30;
  // Control field positions
  localparam int CtlEdgeSelBit = 0;
  localparam int CtlDirBit = 1;
  localparam int CtlInvertBit = 2;
  localparam int CtlStandbyBit = 3;
  localparam logic [3:0] CtlResetValue = 4'h1;
  // Status field positions
  localparam int StsLoadingBit = 0;
  localparam int StsIdxLsb = 4;
  localparam int StsValidBit = 8;
  localparam int StsXferCntLsb = 16;
  localparam logic [1:0] HtransNonseq = 2'h2;

  typedef enum logic [1:0] {
    SdlcIdle = 2'b00,
    SdlcLoad = 2'b01,
    SdlcLast = 2'b11
  } sdlc_state_t;
endpackage
`default_nettype wire

// ---- tb/sdlc_pixel_src.sv ----
`default_nettype none
// Image processor model driving the shared pixel bus
module sdlc_pixel_src
(
  // Clock and phase
  input wire logic ref_clk,
  input wire logic risingSel,
  // Pixel pins
  output logic [sdlc_pkg::DataWidth-1:0] pixelData,
  output logic sequence_start
);
  timeunit 1ns;
  timeprecision 1ps;
  import sdlc_pkg::*;
  initial
  begin
    pixelData = '0;
    sequence_start = 1'b0;
  end
  task automatic act_edge();
    if (risingSel)
      @(posedge ref_clk);
    else
      @(negedge ref_clk);
  endtask
  task automatic send_line(input logic [DataWidth-1:0] w [NumChannels], input int gap);
    repeat (gap) act_edge();
    act_edge();
    sequence_start <= 1'b1;
    for (int j = 0; j < NumChannels; j++)
    begin
      act_edge();
      sequence_start <= 1'b0;
      pixelData <= w[j];
    end
    act_edge();
    // Released bus must not look valid
    pixelData <= ~w[NumChannels-1];
  endtask
endmodule // sdlc_pixel_src
`default_nettype wire

// ---- tb/six_channel_dac_load_control_tb.sv ----
`default_nettype none
module six_channel_dac_load_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sdlc_pkg::*;
  logic refClk, arstN, seqStart, xfer, hsel, hwrite, hreadyout, hresp, polInv, pwrDown, risingSel;
  logic [DataWidth-1:0] pixelData;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [NumChannels*DataWidth-1:0] chanOut;
  logic [DataWidth-1:0] latchM [NumChannels];
  logic [DataWidth-1:0] outM [NumChannels];
  int miscompares, samplesChecked, xferM;

  sdlc_dac_load_ctrl sdlc_dac_load_ctrl_i (
    .ref_clk(refClk), .arst_n(arstN), .pixelData(pixelData), .sequence_start(seqStart),
    .output_transfer(xfer), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .channel_outputs(chanOut),
    .polarity_invert(polInv), .power_down_request(pwrDown));
  sdlc_pixel_src sdlc_pixel_src_i (
    .ref_clk(refClk), .risingSel(risingSel), .pixelData(pixelData),
    .sequence_start(seqStart));

  initial
  begin
    refClk = 1'b0;
    forever #5 refClk = ~refClk;
  end

  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", samplesChecked, miscompares);
    if (miscompares == 0 && samplesChecked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    @(posedge refClk);
    while (hreadyout !== 1'b1)
      @(posedge refClk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge refClk);
    haddr <= a;
    hwrite <= wr;
    htrans <= HtransNonseq;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(rd, exp);
  endtask

  // Latches over the bus, outputs at the pins
  task automatic chk_all();
    for (int i = 0; i < NumChannels; i++)
    begin
      chk_reg(OffsLatchBase + 8'(4 * i), {20'h0, latchM[i]});
      chk_reg(OffsOutBase + 8'(4 * i), {20'h0, outM[i]});
      cmp({20'h0, chanOut[DataWidth*i +: DataWidth]}, {20'h0, outM[i]});
    end
  endtask

  task automatic run_line(input logic [3:0] ctl, input int gap);
    logic [DataWidth-1:0] w [NumChannels];
    bus(1'b1, OffsControl, {28'h0, ctl});
    risingSel = ctl[CtlEdgeSelBit];
    foreach (w[j]) w[j] = 12'($urandom);
    sdlc_pixel_src_i.send_line(w, gap);
    foreach (w[j]) latchM[ctl[CtlDirBit] ? NumChannels - 1 - j : j] = w[j];
    rd = 32'h1;
    while (rd[StsLoadingBit] !== 1'b0)
      bus(1'b0, OffsStatus, 32'h0);
    chk_all();
    @(posedge refClk);
    xfer <= 1'b1;
    xferM++;
    @(posedge refClk);
    xfer <= 1'b0;
    repeat (3) @(posedge refClk);
    outM = latchM;
    chk_all();
  endtask

  initial
  begin
    repeat (20000) @(posedge refClk);
    miscompares++;
    $display("[ERR] t=%0t watchdog expired", $time);
    print_verdict();
  end

  initial
  begin
    void'($urandom(32'h564f));
    miscompares = 0;
    samplesChecked = 0;
    xferM = 0;
    arstN = 1'b0;
    xfer = 1'b0;
    hsel = 1'b1;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    risingSel = 1'b1;
    foreach (latchM[i]) latchM[i] = '0;
    outM = latchM;
    repeat (20) @(posedge refClk);
    arstN <= 1'b1;
    chk_reg(OffsControl, 32'h1);
    bus(1'b1, 8'hfc, 32'hffff_ffff);
    chk_reg(8'hfc, 32'h0);
    // Both edges, both directions, growing delay before start
    for (int m = 0; m < 4; m++)
      run_line(4'(m ^ 1), m);
    bus(1'b1, OffsControl, 32'h5);
    @(posedge refClk);
    cmp({31'h0, polInv}, 32'h1);
    bus(1'b1, OffsControl, 32'hd);
    @(posedge refClk);
    cmp({31'h0, pwrDown}, 32'h1);
    foreach (latchM[i]) latchM[i] = '0;
    outM = latchM;
    chk_all();
    run_line(4'h1, 0);
    cmp({30'h0, polInv, pwrDown}, 32'h0);
    bus(1'b0, OffsStatus, 32'h0);
    cmp(rd >> 16, 32'(xferM));
    print_verdict();
  end
endmodule // six_channel_dac_load_control_tb
`default_nettype wire
